// >>> hw/sspc_pkg.sv
// Shared constants and types of the shutter safety and positioning block
package sspc_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int          CLK_HZ      = 40_000_000;
  localparam int          MS_PER_S    = 1000;
  localparam int          CYC_PER_MS  = CLK_HZ / MS_PER_S;
  localparam logic [15:0] REV_MS_RST  = 16'h02BC;  // 700 ms
  localparam logic [15:0] STEP_MS_RST = 16'h00EB;  // 60 s over 255 steps
  localparam logic [9:0]  MS_IN_S     = 10'h3E7;   // Last ms of a second

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int         AW       = 8;
  localparam logic [7:0] OFS_CFG  = 8'h00;
  localparam logic [7:0] OFS_WDA  = 8'h04;
  localparam logic [7:0] OFS_WDB  = 8'h08;
  localparam logic [7:0] OFS_TIME = 8'h0C;
  localparam logic [7:0] OFS_CMD  = 8'h10;
  localparam logic [7:0] OFS_SAFE = 8'h14;
  localparam logic [7:0] OFS_STAT = 8'h18;

  // Config fields: channel i uses bits CH_STRIDE*i + {EN, POL, POS}
  localparam int CH_STRIDE = 4;
  localparam int F_EN      = 0;
  localparam int F_POL     = 1;
  localparam int F_POS     = 2;
  localparam int F_EXIT    = 8;
  localparam int F_FAIL    = 11;
  localparam int F_REC     = 13;
  localparam int F_REF     = 15;
  localparam int F_APP     = 17;
  localparam int CFG_W     = 19;
  localparam logic [18:0] CFG_RST = 19'h00423;

  // Command word: code in low nibble, target level in bits 15:8
  localparam int F_TGT     = 8;
  localparam int SAFE_SEL  = 1;

  // ****************************************************************
  // Codes
  // ****************************************************************
  localparam logic [2:0] RX_NONE  = 3'h0;
  localparam logic [2:0] RX_UP    = 3'h1;
  localparam logic [2:0] RX_DOWN  = 3'h2;
  localparam logic [2:0] RX_STOP  = 3'h3;
  localparam logic [2:0] RX_SAVED = 3'h4;

  localparam logic [1:0] REF_OFF    = 2'h0;
  localparam logic [1:0] REF_RETURN = 2'h2;

  localparam logic [1:0] APP_DIRECT = 2'h0;
  localparam logic [1:0] APP_UP     = 2'h1;
  localparam logic [1:0] APP_DOWN   = 2'h2;

  localparam logic [3:0] CMD_UP       = 4'h1;
  localparam logic [3:0] CMD_DOWN     = 4'h2;
  localparam logic [3:0] CMD_STOP     = 4'h3;
  localparam logic [3:0] CMD_GOTO     = 4'h4;
  localparam logic [3:0] CMD_REF      = 4'h5;
  localparam logic [3:0] CMD_AUTOGO   = 4'h6;
  localparam logic [3:0] CMD_TOOL_RST = 4'h7;
  localparam logic [3:0] CMD_AUTO_ON  = 4'h8;
  localparam logic [3:0] CMD_AUTO_OFF = 4'h9;

  localparam logic [7:0] POS_TOP    = 8'h00;
  localparam logic [7:0] POS_BOTTOM = 8'hFF;
  localparam logic [7:0] POS_MID    = 8'h80;

  typedef enum logic [1:0] {DRV_OFF, DRV_UP, DRV_DOWN} sspc_drive_type;

endpackage

// >>> hw/sspc_ctrl.sv
// Shutter safety, bus-supply reactions, referencing and positioning
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
module sspc_ctrl #(
  parameter int CYC_PER_MS = sspc_pkg::CYC_PER_MS
) (
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [sspc_pkg::AW-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   bus_supply_loss,
  output logic                        relay_up,
  output logic                        relay_down
);
  import sspc_pkg::*;

  // ****************************************************************
  // APB slave, one wait state so read data comes from a flop
  // ****************************************************************
  logic                 rdy_q;
  logic [31:0]          prdata_q, stat, rd_mux;
  logic [CFG_W-1:0]     cfg_q;
  logic [15:0]          wd_lim_q [2];
  logic [15:0]          rev_ms_q;
  logic [15:0]          step_ms_q;

  wire access   = psel & penable;
  wire wr_fire  = access & pwrite & rdy_q;
  wire hit_cfg  = (paddr == OFS_CFG);
  wire hit_wda  = (paddr == OFS_WDA);
  wire hit_wdb  = (paddr == OFS_WDB);
  wire hit_time = (paddr == OFS_TIME);
  wire hit_cmd  = (paddr == OFS_CMD);
  wire hit_safe = (paddr == OFS_SAFE);
  wire hit_stat = (paddr == OFS_STAT);
  wire mapped   = hit_cfg | hit_wda | hit_wdb | hit_time | hit_cmd
                | hit_safe | hit_stat;
  wire cmd_fire = wr_fire & hit_cmd;
  wire [3:0] cmd_code = pwdata[3:0];
  wire [7:0] cmd_tgt  = pwdata[F_TGT +: 8];
  wire tool_rst = cmd_fire & (cmd_code == CMD_TOOL_RST);

  assign rd_mux = hit_cfg  ? {{(32-CFG_W){1'b0}}, cfg_q} :
                  hit_wda  ? {16'h0000, wd_lim_q[0]} :
                  hit_wdb  ? {16'h0000, wd_lim_q[1]} :
                  hit_time ? {step_ms_q, rev_ms_q} :
                  hit_stat ? stat : 32'h0000_0000;
  assign pready  = rdy_q;
  assign pslverr = rdy_q & ~mapped;
  assign prdata  = prdata_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdy_q    <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      rdy_q    <= access & ~rdy_q;
      prdata_q <= (access & ~rdy_q) ? rd_mux : prdata_q;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q       <= CFG_RST;
      wd_lim_q[0] <= 16'h0000;
      wd_lim_q[1] <= 16'h0000;
      rev_ms_q    <= REV_MS_RST;
      step_ms_q   <= STEP_MS_RST;
    end else if (wr_fire) begin
      if (hit_cfg) cfg_q <= pwdata[CFG_W-1:0];
      if (hit_wda) wd_lim_q[0] <= pwdata[15:0];
      if (hit_wdb) wd_lim_q[1] <= pwdata[15:0];
      if (hit_time) {step_ms_q, rev_ms_q} <= pwdata;
    end
  end

  // ****************************************************************
  // Time base: millisecond and second ticks
  // ****************************************************************
  logic [31:0] ms_cnt_q;
  logic [9:0]  s_cnt_q;
  wire ms_tick  = (ms_cnt_q == 32'(CYC_PER_MS - 1));
  wire sec_tick = ms_tick & (s_cnt_q == MS_IN_S);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt_q <= 32'h0000_0000;
      s_cnt_q  <= 10'h000;
    end else begin
      ms_cnt_q <= ms_tick ? 32'h0000_0000 : ms_cnt_q + 32'h0000_0001;
      if (ms_tick) s_cnt_q <= sec_tick ? 10'h000 : s_cnt_q + 10'h001;
    end
  end

  // ****************************************************************
  // Supply-loss pin synchroniser and edges
  // ****************************************************************
  logic loss_s1_q, loss_s2_q, loss_s3_q;
  wire loss_rise = loss_s2_q & ~loss_s3_q;
  wire loss_fall = ~loss_s2_q & loss_s3_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      {loss_s3_q, loss_s2_q, loss_s1_q} <= 3'h0;
    end else begin
      {loss_s3_q, loss_s2_q, loss_s1_q} <= {loss_s2_q, loss_s1_q,
                                            bus_supply_loss};
    end
  end

  // ****************************************************************
  // Safety channels
  // ****************************************************************
  logic [1:0] act_q;
  logic [15:0] wd_q [2];
  wire saf_tel = wr_fire & hit_safe;

  for (genvar i = 0; i < 2; i++) begin : g_safe
    wire en   = cfg_q[CH_STRIDE*i + F_EN];
    wire pol  = cfg_q[CH_STRIDE*i + F_POL];
    wire tel  = saf_tel & (pwdata[SAFE_SEL] == 1'(i));
    wire wd_on = (wd_lim_q[i] != 16'h0000);
    wire expire = wd_on & sec_tick & (wd_q[i] == 16'h0001);
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        act_q[i] <= 1'b0;
        wd_q[i]  <= 16'h0000;
      end else begin
        // A watchdog expiry in the cycle of a tool reset still arms
        if (!en) act_q[i] <= 1'b0;
        else if (tel) act_q[i] <= (pwdata[0] == pol);
        else if (expire) act_q[i] <= 1'b1;
        else if (tool_rst) act_q[i] <= 1'b0;
        if (tel || tool_rst || expire || !wd_on || wd_q[i] == 16'h0000)
          wd_q[i] <= wd_lim_q[i];
        else if (sec_tick) wd_q[i] <= wd_q[i] - 16'h0001;
      end
    end
  end

  // ****************************************************************
  // Motion control
  // ****************************************************************
  sspc_drive_type drv_q, drv_d, want;
  logic [7:0]  pos_q, pos_d, tgt_q, tgt_d, fin_q, fin_d;
  logic [7:0]  saved_q, saved_d, ret_pos_q, ret_pos_d, pend_tgt_q, pend_tgt_d;
  logic        mov_q, mov_d, via_q, via_d, ref_q, ref_d, ret_q, ret_d;
  logic        pend_q, pend_d, auto_q, auto_d, auto_mem_q, auto_mem_d;
  logic        saf_prev_q;
  logic [15:0] gap_q, step_q;
  logic [2:0]  ev;
  logic [8:0]  leg_cmd, leg_pend, leg_saved;

  wire saf_any  = |act_q;
  wire saf_rise = saf_any & ~saf_prev_q;
  wire saf_fall = ~saf_any & saf_prev_q;
  wire [1:0] app_mode = cfg_q[F_APP +: 2];
  wire [1:0] ref_mode = cfg_q[F_REF +: 2];
  wire [1:0] safe_pos = act_q[0] ? cfg_q[F_POS +: 2]
                                 : cfg_q[CH_STRIDE + F_POS +: 2];
  wire arrive  = mov_q & (pos_q == tgt_q);
  wire running = (drv_q != DRV_OFF);
  wire step_tick = running & ms_tick & (step_q >= step_ms_q);
  wire is_goto = (cmd_code == CMD_GOTO)
               | ((cmd_code == CMD_AUTOGO) & auto_q);

  // First leg of an approach: {via_end_first, first_target}
  function automatic logic [8:0] leg(input logic [1:0] mode,
                                     input logic [7:0] pos,
                                     input logic [7:0] t);
    logic [7:0] e;
    e = (pos < POS_MID) ? POS_TOP : POS_BOTTOM;
    if (mode == APP_UP) e = POS_TOP;
    if (mode == APP_DOWN) e = POS_BOTTOM;
    leg = (mode == APP_DIRECT) ? {1'b0, t} : {1'b1, e};
  endfunction

  assign leg_cmd   = leg(app_mode, pos_q, cmd_tgt);
  assign leg_pend  = leg(app_mode, pos_q, pend_tgt_q);
  assign leg_saved = {1'b0, saved_q};

  // Supply events first, then safety edges; 3-bit code of the reaction
  assign ev = loss_rise ? {1'b0, cfg_q[F_FAIL +: 2]} :
              loss_fall ? {1'b0, cfg_q[F_REC +: 2]} :
              saf_rise  ? {1'b0, safe_pos} :
              saf_fall  ? cfg_q[F_EXIT +: 3] : RX_NONE;

  always_comb begin
    {pos_d, tgt_d, fin_d, saved_d} = {pos_q, tgt_q, fin_q, saved_q};
    {ret_pos_d, pend_tgt_d} = {ret_pos_q, pend_tgt_q};
    {mov_d, via_d, ref_d} = {mov_q, via_q, ref_q};
    {ret_d, pend_d, auto_d, auto_mem_d} = {ret_q, pend_q, auto_q, auto_mem_q};
    if (step_tick) begin
      pos_d = (drv_q == DRV_UP) ? pos_q - 8'h01 : pos_q + 8'h01;
    end
    if (arrive) begin
      mov_d = 1'b0;
      if (via_q) begin
        tgt_d = fin_q;
        via_d = 1'b0;
        mov_d = 1'b1;
      end else if (ref_q) begin
        ref_d = 1'b0;
        if (pend_q) begin
          pend_d = 1'b0;
          {via_d, tgt_d} = leg_pend;
          fin_d = pend_tgt_q;
          mov_d = 1'b1;
        end else if (ref_mode == REF_RETURN) begin
          tgt_d = ret_pos_q;
          ret_d = 1'b1;
          mov_d = 1'b1;
        end
      end else if (ret_q) begin
        ret_d = 1'b0;
        if (auto_mem_q) auto_d = 1'b1;
      end
    end
    if (saf_rise) saved_d = via_q ? fin_q : (mov_q ? tgt_q : pos_q);
    if (ev != RX_NONE) begin
      ref_d = 1'b0;
      ret_d = 1'b0;
      pend_d = 1'b0;
      via_d = 1'b0;
      mov_d = 1'b1;
      case (ev)
        RX_UP: begin
          tgt_d = POS_TOP;
        end
        RX_DOWN: begin
          tgt_d = POS_BOTTOM;
        end
        RX_SAVED: begin
          {via_d, tgt_d} = leg_saved;
        end
        default: begin
          mov_d = 1'b0;
        end
      endcase
    end else if (cmd_fire && saf_any) begin
      if (is_goto) saved_d = cmd_tgt;
    end else if (cmd_fire) begin
      if (cmd_code == CMD_UP || cmd_code == CMD_DOWN
          || cmd_code == CMD_STOP) begin
        ref_d = 1'b0;
        ret_d = 1'b0;
        pend_d = 1'b0;
        via_d = 1'b0;
        mov_d = (cmd_code != CMD_STOP);
        tgt_d = (cmd_code == CMD_UP) ? POS_TOP : POS_BOTTOM;
      end else if (is_goto && ref_q) begin
        pend_d = 1'b1;
        pend_tgt_d = cmd_tgt;
      end else if (is_goto) begin
        {via_d, tgt_d} = leg_cmd;
        fin_d = cmd_tgt;
        mov_d = 1'b1;
        ret_d = 1'b0;
      end else if (cmd_code == CMD_REF && ref_mode != REF_OFF) begin
        ref_d = 1'b1;
        ret_d = 1'b0;
        pend_d = 1'b0;
        ret_pos_d = via_q ? fin_q : (mov_q ? tgt_q : pos_q);
        auto_mem_d = auto_q;
        auto_d = 1'b0;
        pos_d = POS_BOTTOM;
        tgt_d = POS_TOP;
        via_d = 1'b0;
        mov_d = 1'b1;
      end else if (cmd_code == CMD_AUTO_ON) begin
        auto_d = 1'b1;
      end else if (cmd_code == CMD_AUTO_OFF) begin
        auto_d = 1'b0;
      end
    end
  end

  // ****************************************************************
  // Relay driver with reversing gap
  // ****************************************************************
  // Any de-energising loads the gap, so a stop followed by the other
  // direction also honours the reversing time
  assign want = (!mov_q || pos_q == tgt_q) ? DRV_OFF :
                (tgt_q < pos_q) ? DRV_UP : DRV_DOWN;

  always_comb begin
    drv_d = drv_q;
    case (drv_q)
      DRV_OFF: begin
        if (gap_q == 16'h0000) drv_d = want;
      end
      default: begin
        if (want != drv_q) drv_d = DRV_OFF;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      drv_q <= DRV_OFF;
      gap_q <= 16'h0000;
      step_q <= 16'h0000;
    end else begin
      drv_q <= drv_d;
      if (running && drv_d == DRV_OFF) gap_q <= rev_ms_q + 16'h0001;
      else if (ms_tick && gap_q != 16'h0000) gap_q <= gap_q - 16'h0001;
      if (!running || step_tick) step_q <= 16'h0000;
      else if (ms_tick) step_q <= step_q + 16'h0001;
    end
  end

  assign relay_up   = (drv_q == DRV_UP);
  assign relay_down = (drv_q == DRV_DOWN);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      {pos_q, tgt_q, fin_q} <= {3{POS_TOP}};
      {saved_q, ret_pos_q, pend_tgt_q} <= {3{POS_TOP}};
      {mov_q, via_q, ref_q, ret_q, pend_q} <= 5'h00;
      {auto_q, auto_mem_q, saf_prev_q} <= 3'h0;
    end else begin
      {pos_q, tgt_q, fin_q} <= {pos_d, tgt_d, fin_d};
      {saved_q, ret_pos_q, pend_tgt_q} <= {saved_d, ret_pos_d, pend_tgt_d};
      {mov_q, via_q, ref_q, ret_q, pend_q} <=
        {mov_d, via_d, ref_d, ret_d, pend_d};
      {auto_q, auto_mem_q, saf_prev_q} <= {auto_d, auto_mem_d, saf_any};
    end
  end

  assign stat = {16'h0000, loss_s2_q, auto_q, pend_q, ref_q, mov_q,
                 act_q, relay_down, pos_q};
endmodule

// >>> sim/sspc_chk_assertions.sv
// Port checker of the shutter safety and positioning block
`timescale 1ns/100ps
module sspc_chk #(
  parameter int CYC_PER_MS = sspc_pkg::CYC_PER_MS
) (
  input wire logic                    ref_clk,
  input wire logic                    rst_n,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [sspc_pkg::AW-1:0] paddr,
  input wire logic [31:0]             pwdata,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire logic                    bus_supply_loss,
  input wire logic                    relay_up,
  input wire logic                    relay_down
);
  import sspc_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ****************************************************************
  // Helper logic
  // ****************************************************************
  // Safety may be armed once any safety or watchdog write was seen; STOP is then
  // allowed to be ignored, so the stop check stands down for good
  logic sfe_q;
  logic sfe_d;
  wire  acc    = psel && penable && pready;
  wire  wr_cmd = acc && pwrite && paddr == OFS_CMD;
  wire  wr_sfe = acc && pwrite && paddr inside {OFS_SAFE, OFS_WDA, OFS_WDB};
  assign sfe_d = sfe_q || wr_sfe;
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      sfe_q <= 1'b0;
    else
      sfe_q <= sfe_d;
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  sequence s_done;
    psel && penable && pready;
  endsequence
  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_ready_wait: assert property ($rose(penable) && psel |-> s_wait ##1 s_done)
    else $error("pready not one cycle after access start");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_sel: assert property (pready |-> psel && penable)
    else $error("pready outside an access");
  a_err_map: assert property (pready && paddr[1:0] == 2'h0
    |-> pslverr == (paddr > OFS_STAT))
    else $error("pslverr does not match the address map");
  a_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 0)
    else $error("refused read returned data");
  a_cmd_zero: assert property (pready && !pwrite && paddr == OFS_CMD
    |-> prdata == 32'h0)
    else $error("command word read back nonzero");
  a_relay_excl: assert property (!(relay_up && relay_down))
    else $error("both relays energised");
  a_up_gap: assert property ($fell(relay_up) |-> (!relay_up && !relay_down) [*8])
    else $error("relay fed again too soon after up run");
  a_dn_gap: assert property ($fell(relay_down) |-> (!relay_up && !relay_down) [*8])
    else $error("relay fed again too soon after down run");
  a_stop_drop: assert property (wr_cmd && pwdata[3:0] == CMD_STOP && !sfe_q
    && !bus_supply_loss |-> ##2 (!relay_up && !relay_down))
    else $error("stop did not release the relays");
endmodule
bind sspc_ctrl sspc_chk #(.CYC_PER_MS(CYC_PER_MS)) chk_u (
  .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .bus_supply_loss(bus_supply_loss),
  .relay_up(relay_up), .relay_down(relay_down));

// >>> sim/sspc_motor.sv
// Drive motor model that logs the shortest dead time between runs
`timescale 1ns/100ps
module sspc_motor (
  input wire logic  ref_clk,
  input wire logic  rst_n,
  input wire logic  relay_up,
  input wire logic  relay_down,
  output logic [15:0] min_gap
);
  logic [15:0] idle_q;
  logic        ran_q;
  wire         on = relay_up || relay_down;
  // A restart with little dead time strains the gearbox; log the worst
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_q  <= 16'h0000;
      ran_q   <= 1'b0;
      min_gap <= 16'hFFFF;
    end else if (on) begin
      if (ran_q && idle_q != 16'h0000 && idle_q < min_gap)
        min_gap <= idle_q;
      idle_q <= 16'h0000;
      ran_q  <= 1'b1;
    end else if (idle_q != 16'hFFFF) begin
      idle_q <= idle_q + 16'h0001;
    end
  end
endmodule

// >>> sim/sspc_ctrl_tb.sv
// Self-checking bench of the shutter safety and positioning block
`timescale 1ns/100ps
module sspc_ctrl_tb;
  import sspc_pkg::*;
  localparam int CPM = 4;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        bus_supply_loss = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        relay_up;
  logic        relay_down;
  logic [15:0] min_gap;
  logic [31:0] q;
  logic        e;
  int          err_total = 0;
  int          samples_checked = 0;
  always #12.5 ref_clk = ~ref_clk;
  sspc_ctrl #(.CYC_PER_MS(CPM)) dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bus_supply_loss(bus_supply_loss),
    .relay_up(relay_up), .relay_down(relay_down));
  sspc_motor mot_u (.ref_clk(ref_clk), .rst_n(rst_n), .relay_up(relay_up),
    .relay_down(relay_down), .min_gap(min_gap));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Request holds until the rising edge that samples pready high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) chk_w(32'h0, 32'h1);
  endtask
  task automatic cmd(input logic [3:0] c, input logic [7:0] t);
    apb(1'b1, OFS_CMD, {16'h0000, t, 4'h0, c});
  endtask
  task automatic wait_rel(input logic [1:0] x, input int lim);
    int n;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while ({relay_down, relay_up} !== x && n < lim);
    chk_w({30'h0, relay_down, relay_up}, {30'h0, x});
  endtask
  task automatic settle(input logic [2:0] m, input logic [7:0] p);
    int n;
    n = 0;
    do begin
      apb(1'b0, OFS_STAT, 32'h0);
      n++;
    end while ((q[13:11] & m) !== 3'h0 && n < 4000);
    chk_w({24'h0, q[7:0]}, {24'h0, p});
  endtask
  task automatic end_sim;
    if (err_total == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge ref_clk);
    err_total++;
    end_sim;
  end
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    apb(1'b0, OFS_CFG, 32'h0);
    chk_w(q, {13'h0, CFG_RST});
    apb(1'b0, OFS_TIME, 32'h0);
    chk_w(q, {STEP_MS_RST, REV_MS_RST});
    apb(1'b0, 8'h1C, 32'h0);
    chk_w({31'h0, e}, 32'h1);
    chk_w(q, 32'h0);
    apb(1'b0, OFS_CMD, 32'h0);
    chk_w(q, 32'h0);
    // Short step and reversing times keep full travel near 2000 cycles
    apb(1'b1, OFS_TIME, {16'h0001, 16'h0005});
    cmd(CMD_GOTO, 8'h10);
    wait_rel(2'b10, 3000);
    settle(3'h7, 8'h10);
    cmd(CMD_GOTO, 8'hC8);
    wait_rel(2'b10, 3000);
    cmd(CMD_STOP, 8'h00);
    wait_rel(2'b00, 6);
    cmd(CMD_GOTO, 8'h08);
    wait_rel(2'b01, 3000);
    settle(3'h7, 8'h08);
    apb(1'b1, OFS_CFG, 32'h0042B);
    apb(1'b1, OFS_SAFE, 32'h1);
    apb(1'b0, OFS_STAT, 32'h0);
    chk_w({31'h0, q[9]}, 32'h1);
    wait_rel(2'b10, 3000);
    cmd(CMD_GOTO, 8'h20);
    settle(3'h1, 8'hFF);
    apb(1'b1, OFS_SAFE, 32'h0);
    apb(1'b0, OFS_STAT, 32'h0);
    chk_w({31'h0, q[9]}, 32'h0);
    settle(3'h7, 8'h20);
    apb(1'b1, OFS_CFG, 32'h003D3);
    cmd(CMD_GOTO, 8'hC8);
    wait_rel(2'b10, 3000);
    apb(1'b1, OFS_SAFE, 32'h2);
    wait_rel(2'b00, 6);
    apb(1'b0, OFS_STAT, 32'h0);
    chk_w({30'h0, q[10:9]}, 32'h2);
    apb(1'b1, OFS_SAFE, 32'h3);
    repeat (40) @(posedge ref_clk);
    apb(1'b0, OFS_STAT, 32'h0);
    chk_w({29'h0, q[11:9]}, 32'h0);
    apb(1'b1, OFS_CFG, 32'h00303);
    apb(1'b1, OFS_WDA, 32'h2);
    repeat (3000) @(posedge ref_clk);
    apb(1'b0, OFS_STAT, 32'h0);
    chk_w({31'h0, q[9]}, 32'h0);
    repeat (6000) @(posedge ref_clk);
    apb(1'b0, OFS_STAT, 32'h0);
    chk_w({31'h0, q[9]}, 32'h1);
    apb(1'b1, OFS_WDA, 32'h0);
    cmd(CMD_TOOL_RST, 8'h00);
    apb(1'b0, OFS_STAT, 32'h0);
    chk_w({30'h0, q[10:9]}, 32'h0);
    apb(1'b1, OFS_CFG, 32'h06B03);
    cmd(CMD_GOTO, 8'hF0);
    wait_rel(2'b10, 3000);
    apb(1'b1, OFS_SAFE, 32'h1);
    bus_supply_loss <= 1'b1;
    wait_rel(2'b01, 200);
    @(posedge ref_clk);
    bus_supply_loss <= 1'b0;
    wait_rel(2'b00, 8);
    apb(1'b0, OFS_STAT, 32'h0);
    chk_w({31'h0, q[9]}, 32'h1);
    apb(1'b1, OFS_SAFE, 32'h0);
    apb(1'b0, OFS_STAT, 32'h0);
    chk_w({31'h0, q[9]}, 32'h0);
    cmd(CMD_REF, 8'h00);
    repeat (40) @(posedge ref_clk);
    apb(1'b0, OFS_STAT, 32'h0);
    chk_w({29'h0, q[13:11]}, 32'h0);
    apb(1'b1, OFS_CFG, 32'h08303);
    cmd(CMD_REF, 8'h00);
    wait_rel(2'b01, 3000);
    settle(3'h7, 8'h00);
    cmd(CMD_REF, 8'h00);
    cmd(CMD_GOTO, 8'h64);
    apb(1'b0, OFS_STAT, 32'h0);
    chk_w({31'h0, q[13]}, 32'h1);
    settle(3'h7, 8'h64);
    apb(1'b1, OFS_CFG, 32'h48303);
    cmd(CMD_GOTO, 8'h32);
    wait_rel(2'b10, 3000);
    settle(3'h7, 8'h32);
    apb(1'b1, OFS_CFG, 32'h68303);
    cmd(CMD_GOTO, 8'hC8);
    wait_rel(2'b01, 3000);
    settle(3'h7, 8'hC8);
    apb(1'b1, OFS_CFG, 32'h10303);
    cmd(CMD_AUTO_ON, 8'h00);
    cmd(CMD_REF, 8'h00);
    settle(3'h7, 8'hC8);
    chk_w({31'h0, q[14]}, 32'h1);
    chk_w({31'h0, min_gap >= 16'h0014}, 32'h1);
    end_sim;
  end
endmodule
